// ---- verification/pcs_board_model.sv ----
// Behavioural model of the PCI slots and the board clock generator.
module pcs_board_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_slot_slow,
    input  wire logic       i_i2c_prog,
    output logic            o_m66en,
    output logic            o_gen_programmed_60mhz
);
    timeunit 1ns;
    timeprecision 1ps;
    // The shared line is pulled up, and any slow-only card pulls it low.
    assign o_m66en = ~|i_slot_slow;
    // Generator programming is volatile, so a power-on reset drops it.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gen_programmed_60mhz <= 1'b0;
        end else if (i_i2c_prog) begin
            o_gen_programmed_60mhz <= 1'b1;
        end
    end
endmodule

// ---- verification/pcs_clock_speed_select_test.sv ----
// Self-checking testbench of the PCI clock speed select block.
module pcs_clock_speed_select_test import pcs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 0, rst_n = 0, jmp = 0, fwr = 0, fwd = 0, uwr = 0, prog = 0;
    logic [3:0]   slow = 4'h0;
    pcs_usb_src_t usrc = PCS_USB_FROM_PHY;
    logic         m66, gp, sel, fen, m66s, gen_en, from_gen, rstr;
    int           n_mismatch = 0, n_checks = 0;
    always #12.5 clk = ~clk;
    pcs_board_model brd_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_slot_slow(slow), .i_i2c_prog(prog),
        .o_m66en(m66), .o_gen_programmed_60mhz(gp));
    pcs_clock_speed_select dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_m66en(m66), .i_jumper_fitted(jmp),
        .i_fast_clock_enable_wr(fwr), .i_fast_clock_enable_wdata(fwd), .i_usb_src_wr(uwr),
        .i_usb_src_wdata(usrc), .i_gen_programmed_60mhz(gp), .o_clock_speed_select_out(sel),
        .o_fast_clock_enable(fen), .o_m66en_status(m66s), .o_generator_usb_clock_output_en(gen_en),
        .o_usb_clock_input_from_gen(from_gen), .o_generator_factory_restore(rstr));
    // Waits for rising edges, then lets the inputs change a little later.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Compares one bit and counts the result.
    task automatic chk(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Writes the fast clock enable bit with a one-cycle strobe.
    task automatic wr_en(input logic v);
        fwr = 1'b1;
        fwd = v;
        step(1);
        fwr = 1'b0;
    endtask
    // Writes the USB clock source with a one-cycle strobe, then settles.
    task automatic wr_usb(input pcs_usb_src_t s);
        uwr = 1'b1;
        usrc = s;
        step(1);
        uwr = 1'b0;
        step(2);
    endtask
    // Checks the USB source outputs against one expected level.
    task automatic chk_usb(input logic exp);
        chk("usb_from_gen", exp, from_gen);
        chk("gen_usb_en", exp, gen_en);
    endtask
    // Main sequence: reset, all select combinations, USB source, reset mid-run.
    initial begin
        step(1);
        chk("select_rst", 1'b0, sel);
        chk("enable_rst", 1'b0, fen);
        chk_usb(1'b0);
        chk("restore_rst", 1'b1, rstr);
        step(15);
        rst_n = 1'b1;
        chk("restore_hold", 1'b1, rstr);
        step(6);
        chk("restore_end", 1'b0, rstr);
        for (int i = 0; i < 8; i++) begin
            jmp = i[0];
            slow = i[1] ? 4'h0 : 4'h1 << (i % 4);
            wr_en(i[2]);
            step(5);
            chk("select", !i[0] && i[1] && i[2], sel);
            chk("enable_rb", i[2], fen);
            chk("m66en_status", i[1], m66s);
        end
        wr_usb(PCS_USB_FROM_GEN);
        chk_usb(1'b0);
        prog = 1'b1;
        step(1);
        prog = 1'b0;
        wr_usb(PCS_USB_FROM_GEN);
        chk_usb(1'b1);
        wr_usb(PCS_USB_FROM_PHY);
        chk_usb(1'b0);
        wr_usb(PCS_USB_FROM_GEN);
        jmp = 1'b0;
        step(5);
        chk("select_fast", 1'b1, sel);
        slow = 4'h8;
        step(1);
        chk("select_sync1", 1'b1, sel);
        step(1);
        chk("select_sync2", 1'b1, sel);
        step(1);
        chk("select_slow", 1'b0, sel);
        rst_n = 1'b0;
        step(1);
        chk("select_rst2", 1'b0, sel);
        chk_usb(1'b0);
        rst_n = 1'b1;
        step(6);
        chk("select_after", 1'b0, sel);
        wr_usb(PCS_USB_FROM_GEN);
        chk_usb(1'b0);
        final_report();
    end
endmodule

// ---- verilog/pcs_clock_speed_select.sv ----
// Top of the PCI clock speed select block.
// How it works
// - Select high needs jumper off, M66EN, enable.
// - Any other combination drives select low.
// - Fast clock enable bit resets cleared.
// - Generator I2C settings dropped at power-on reset.
// - USB clock from PHY at reset, generator output off.
// - Software reaches enable bit; jumper is manual.
module pcs_clock_speed_select
    import pcs_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_m66en,
    input  wire logic i_jumper_fitted,
    input  wire logic i_fast_clock_enable_wr,
    input  wire logic i_fast_clock_enable_wdata,
    input  wire logic i_usb_src_wr,
    input  wire pcs_pkg::pcs_usb_src_t i_usb_src_wdata,
    input  wire logic i_gen_programmed_60mhz,
    output logic      o_clock_speed_select_out,
    output logic      o_fast_clock_enable,
    output logic      o_m66en_status,
    output logic      o_generator_usb_clock_output_en,
    output logic      o_usb_clock_input_from_gen,
    output logic      o_generator_factory_restore
);
    logic                 m66en_s;
    logic                 jumper_s;
    logic                 fast_en_q;
    logic                 sel_q;
    logic                 m66_q;
    pcs_usb_src_t         usb_src_q;
    logic                 gen_usb_en_q;
    logic [3:0]           hold_cnt_q;
    logic                 restore_q;
    logic [1:0]           pin_raw;
    logic [1:0]           pin_sync;
    wire                  sel_d;

    // True when the jumper is off, every card is fast and software allows the fast setting.
    function automatic logic fast_allowed(input logic jumper, input logic m66en, input logic enable);
        return !jumper && m66en && enable;
    endfunction

    // Board inputs gathered for the synchronisers: bit 0 is M66EN, bit 1 the speed jumper.
    assign pin_raw = {i_jumper_fitted, i_m66en};

    // Each board input passes its own two-flop synchroniser, so a change never races the combine.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        pcs_sync u_sync (
            .i_core_clk (i_core_clk),
            .i_rst_n    (i_rst_n),
            .i_level    (pin_raw[g]),
            .i_rst_val  (1'b0),
            .o_level    (pin_sync[g])
        );
    end

    // Synchronised copies of the two board inputs.
    assign m66en_s  = pin_sync[0];
    assign jumper_s = pin_sync[1];

    // Select is high only when all three conditions agree.
    assign sel_d = fast_allowed(jumper_s, m66en_s, fast_en_q);

    // Software enable bit, cleared on reset.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_en_q <= FAST_CLOCK_ENABLE_RST;
        end else if (i_fast_clock_enable_wr) begin
            fast_en_q <= i_fast_clock_enable_wdata;
        end
    end

    // Registered select output, so it never glitches.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_q <= FREQ_SELECT_RST;
            m66_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            m66_q <= m66en_s;
        end
    end

    // USB clock source: PHY by default; generator only once it is programmed.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            usb_src_q    <= PCS_USB_FROM_PHY;
            gen_usb_en_q <= GEN_USB_EN_RST;
        end else if (i_usb_src_wr) begin
            if (i_usb_src_wdata == PCS_USB_FROM_GEN && i_gen_programmed_60mhz) begin
                usb_src_q    <= PCS_USB_FROM_GEN;
                gen_usb_en_q <= 1'b1;
            end else begin
                usb_src_q    <= PCS_USB_FROM_PHY;
                gen_usb_en_q <= 1'b0;
            end
        end
    end

    // After reset, the generator is told to restore factory settings.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_cnt_q <= FACTORY_HOLD_CYCLES;
            restore_q  <= 1'b1;
        end else if (hold_cnt_q != 4'h0) begin
            hold_cnt_q <= hold_cnt_q - 4'h1;
            restore_q  <= 1'b1;
        end else begin
            restore_q  <= 1'b0;
        end
    end

    assign o_clock_speed_select_out        = sel_q;
    assign o_fast_clock_enable             = fast_en_q;
    assign o_m66en_status                  = m66_q;
    assign o_generator_usb_clock_output_en = gen_usb_en_q;
    assign o_usb_clock_input_from_gen      = logic'(usb_src_q);
    assign o_generator_factory_restore     = restore_q;

    // Select high needs all three conditions, a cycle later.
    property p_sel_high;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_clock_speed_select_out |-> (!$past(jumper_s) && $past(m66en_s) && $past(fast_en_q));
    endproperty
    a_sel_high: assert property (p_sel_high) else $error("select high without all conditions");

    // Any missing condition drives the select low on the next edge.
    property p_sel_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fast_allowed(jumper_s, m66en_s, fast_en_q) |=> !o_clock_speed_select_out;
    endproperty
    a_sel_low: assert property (p_sel_low) else $error("select not low");

    // A cleared enable bit alone keeps the slow setting.
    property p_sel_low_fast;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !fast_en_q |=> !o_clock_speed_select_out;
    endproperty
    a_sel_low_fast: assert property (p_sel_low_fast) else $error("select high with enable clear");

    // A falling M66EN line reaches the select through the synchroniser in three edges.
    property p_m66_path;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $fell(i_m66en) |-> ##3 !o_clock_speed_select_out;
    endproperty
    a_m66_path: assert property (p_m66_path) else $error("M66EN low not seen in three cycles");

    // A fitted jumper reaches the select through the synchroniser in three edges.
    property p_jumper_path;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_jumper_fitted) |-> ##3 !o_clock_speed_select_out;
    endproperty
    a_jumper_path: assert property (p_jumper_path) else $error("jumper not seen in three cycles");

    // The generator USB output is only on while it is the chosen source.
    property p_usb_default;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !o_usb_clock_input_from_gen |-> !o_generator_usb_clock_output_en;
    endproperty
    a_usb_default: assert property (p_usb_default) else $error("generator USB clock on while unused");

    // An unprogrammed generator is never taken as the USB source.
    property p_usb_gen;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_usb_src_wr && !i_gen_programmed_60mhz) |=> !o_usb_clock_input_from_gen;
    endproperty
    a_usb_gen: assert property (p_usb_gen) else $error("generator chosen before programming");

    // A programmed generator is taken and its USB output switched on.
    property p_usb_gen_on;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_usb_src_wr && i_usb_src_wdata == PCS_USB_FROM_GEN && i_gen_programmed_60mhz)
            |=> (o_usb_clock_input_from_gen && o_generator_usb_clock_output_en);
    endproperty
    a_usb_gen_on: assert property (p_usb_gen_on) else $error("programmed generator not taken");

    // Choosing the PHY turns the generator USB output off.
    property p_usb_phy;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_usb_src_wr && i_usb_src_wdata == PCS_USB_FROM_PHY)
            |=> (!o_usb_clock_input_from_gen && !o_generator_usb_clock_output_en);
    endproperty
    a_usb_phy: assert property (p_usb_phy) else $error("PHY source not taken");

    // Leaving reset, the USB clock comes from the PHY with the generator output off.
    property p_usb_rst;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> (!o_usb_clock_input_from_gen && !o_generator_usb_clock_output_en);
    endproperty
    a_usb_rst: assert property (p_usb_rst) else $error("USB source not at default after reset");

    // A write strobe lands in the enable bit on the next edge.
    property p_wr;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_fast_clock_enable_wr |=> (o_fast_clock_enable == $past(i_fast_clock_enable_wdata));
    endproperty
    a_wr: assert property (p_wr) else $error("enable write lost");

    // Leaving reset, the enable bit is cleared.
    property p_enable_rst;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> !o_fast_clock_enable;
    endproperty
    a_enable_rst: assert property (p_enable_rst) else $error("enable bit set after reset");

    // Leaving reset, the generator is told to drop its settings.
    property p_restore;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> o_generator_factory_restore;
    endproperty
    a_restore: assert property (p_restore) else $error("no factory restore after reset");

    // The restore request ends once the hold count has run out.
    property p_restore_end;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> ##4 o_generator_factory_restore ##1 !o_generator_factory_restore;
    endproperty
    a_restore_end: assert property (p_restore_end) else $error("factory restore length wrong");

    // Main scenarios: fast and slow selection, USB source change, refusal and restore end.
    c_fast: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_clock_speed_select_out));
    c_slow: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $fell(o_clock_speed_select_out));
    c_usb:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_usb_clock_input_from_gen));
    c_refused: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_usb_src_wr && i_usb_src_wdata == PCS_USB_FROM_GEN && !i_gen_programmed_60mhz);
    c_restore: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $fell(o_generator_factory_restore));
endmodule

// ---- verilog/pcs_pkg.sv ----
// Package with the constants shared by the PCI clock speed select block.
package pcs_pkg;

    // Value of the fast clock enable bit after reset: cleared gives 33 MHz.
    localparam logic FAST_CLOCK_ENABLE_RST  = 1'b0;
    // Value of the frequency select output after reset: low gives 33 MHz.
    localparam logic FREQ_SELECT_RST        = 1'b0;
    // USB clock source after reset: 0 selects the PHY 60 MHz output.
    localparam logic USB_SRC_RST            = 1'b0;
    // Generator USB clock output enable after reset: disabled.
    localparam logic GEN_USB_EN_RST         = 1'b0;
    // Number of synchroniser stages on each board input.
    localparam int   SYNC_STAGES            = 2;
    // Cycles the generator I2C config is held in reset-to-factory after reset release.
    localparam logic [3:0] FACTORY_HOLD_CYCLES = 4'h4;

    // USB clock source selection.
    typedef enum logic {
        PCS_USB_FROM_PHY,
        PCS_USB_FROM_GEN
    } pcs_usb_src_t;

endpackage

// ---- verilog/pcs_sync.sv ----
// Two-stage synchroniser for one level input.
module pcs_sync (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    input  wire logic i_rst_val,
    output logic      o_level
);
    logic meta_q;
    logic sync_q;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_level;
            sync_q <= meta_q;
        end
    end

    assign o_level = sync_q;

    // Unused reset value input kept for a uniform port list.
    logic unused_rst_val;
    assign unused_rst_val = i_rst_val;
endmodule
